// File: verilog/frld_line_engine.sv
// thick line drawing engine with register port and scan configuration
//
// Added by the designer: strobed register access and the placing of the registers.
module frld_line_engine
  import frld_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic             irq,
  output logic      [2:0]  function_select,
  output logic             operation_trigger,
  input  wire logic        ext_done,
  output frld_scan_s       scan_cfg,
  output frld_mem_s        mem_wr,
  input  wire logic        mem_ready
);

  // ==========================================================
  // helpers
  // packed bytes per frame buffer line
  function automatic logic [9:0] line_bytes(input logic [9:0] s, input logic [1:0] f);
    logic [10:0] t;
    t = {1'b0, s};
    case (f)
      FMT_C3:   line_bytes = 10'((t + 11'h001) >> 1);
      FMT_MONO: line_bytes = 10'((t + 11'h003) >> 2);
      default:  line_bytes = s;
    endcase
  endfunction : line_bytes

  function automatic logic [11:0] abs_diff(input logic [9:0] a, input logic [9:0] b);
    abs_diff = (a >= b) ? {2'h0, a - b} : {2'h0, b - a};
  endfunction : abs_diff

  // ==========================================================
  // register state
  logic [2:0]  func_q, func_d;
  logic        trig_q, trig_d;
  logic        flag_q, flag_d;
  logic        ien_q, ien_d;
  logic [31:0] obase_q, obase_d;
  logic [9:0]  ostr_q, ostr_d, x1_q, x1_d, y1_q, y1_d, x2_q, x2_d, y2_q, y2_d;
  logic [9:0]  thick_q, thick_d, owid_q, owid_d, ohgt_q, ohgt_d;
  logic [7:0]  color_q, color_d;
  logic [5:0]  pcfg_q, pcfg_d;
  logic [9:0]  swid_q, swid_d, shgt_q, shgt_d, sstr_q, sstr_d;
  logic [31:0] sbase_q, sbase_d, rdata_q, rdata_d;
  logic        eng_done;

  // ==========================================================
  // engine state
  frld_state_e        st_q, st_d;
  logic signed [11:0] cx_q, cx_d, cy_q, cy_d, off_q, off_d;
  logic signed [12:0] err_q, err_d, e2;
  logic [11:0]        dx_q, dx_d, dy_q, dy_d;
  logic               sxn_q, sxn_d, syn_q, syn_d, xmaj_q, xmaj_d;
  frld_mem_s          mem_q, mem_d;
  logic signed [11:0] px, py, nthick;
  logic               inb, adv, at_end;
  logic [19:0]        yoff;
  logic [9:0]         xbyte;
  logic [7:0]         pmask, pdata;

  // register next values; a set of the flag beats a clear in the same cycle
  always_comb begin
    func_d  = func_q;
    trig_d  = trig_q;
    flag_d  = flag_q;
    ien_d   = ien_q;
    obase_d = obase_q;
    ostr_d  = ostr_q;
    x1_d    = x1_q;
    y1_d    = y1_q;
    x2_d    = x2_q;
    y2_d    = y2_q;
    thick_d = thick_q;
    color_d = color_q;
    owid_d  = owid_q;
    ohgt_d  = ohgt_q;
    pcfg_d  = pcfg_q;
    swid_d  = swid_q;
    shgt_d  = shgt_q;
    sstr_d  = sstr_q;
    sbase_d = sbase_q;
    rdata_d = 32'h0000_0000;
    if (reg_wr) begin
      case (reg_addr)
        REG_FUNC:  func_d = reg_wdata[2:0];
        REG_TRIG:  if (reg_wdata[0]) trig_d = 1'b1;
        REG_INTST: if (reg_wdata[0]) flag_d = 1'b0;
        REG_INTEN: ien_d = reg_wdata[0];
        REG_OBLO:  obase_d[15:0] = reg_wdata[15:0];
        REG_OBHI:  obase_d[31:16] = reg_wdata[15:0];
        REG_OSTR:  ostr_d = reg_wdata[9:0];
        REG_X1:    x1_d = reg_wdata[9:0];
        REG_Y1:    y1_d = reg_wdata[9:0];
        REG_X2:    x2_d = reg_wdata[9:0];
        REG_Y2:    y2_d = reg_wdata[9:0];
        REG_THICK: thick_d = reg_wdata[9:0];
        REG_COLOR: color_d = reg_wdata[7:0];
        REG_OWID:  owid_d = reg_wdata[9:0];
        REG_OHGT:  ohgt_d = reg_wdata[9:0];
        REG_PCFG:  pcfg_d = reg_wdata[5:0];
        REG_SWID:  swid_d = reg_wdata[9:0];
        REG_SHGT:  shgt_d = reg_wdata[9:0];
        REG_SSTR:  sstr_d = reg_wdata[9:0];
        REG_SBLO:  sbase_d[15:0] = reg_wdata[15:0];
        REG_SBHI:  sbase_d[31:16] = reg_wdata[15:0];
        default:   ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        REG_FUNC:  rdata_d = {29'h0, func_q};
        REG_TRIG:  rdata_d = {31'h0, trig_q};
        REG_INTST: rdata_d = {31'h0, flag_q};
        REG_INTEN: rdata_d = {31'h0, ien_q};
        REG_OBLO:  rdata_d = {16'h0, obase_q[15:0]};
        REG_OBHI:  rdata_d = {16'h0, obase_q[31:16]};
        REG_OSTR:  rdata_d = {22'h0, ostr_q};
        REG_X1:    rdata_d = {22'h0, x1_q};
        REG_Y1:    rdata_d = {22'h0, y1_q};
        REG_X2:    rdata_d = {22'h0, x2_q};
        REG_Y2:    rdata_d = {22'h0, y2_q};
        REG_THICK: rdata_d = {22'h0, thick_q};
        REG_COLOR: rdata_d = {24'h0, color_q};
        REG_OWID:  rdata_d = {22'h0, owid_q};
        REG_OHGT:  rdata_d = {22'h0, ohgt_q};
        REG_PCFG:  rdata_d = {26'h0, pcfg_q};
        REG_SWID:  rdata_d = {22'h0, swid_q};
        REG_SHGT:  rdata_d = {22'h0, shgt_q};
        REG_SSTR:  rdata_d = {22'h0, sstr_q};
        REG_SBLO:  rdata_d = {16'h0, sbase_q[15:0]};
        REG_SBHI:  rdata_d = {16'h0, sbase_q[31:16]};
        REG_STAT:  rdata_d = {31'h0, st_q != ST_IDLE};
        default:   rdata_d = 32'h0000_0000;
      endcase
      if (reg_addr == REG_INTST) flag_d = 1'b0; // status read also clears
    end
    // other functions finish through the neighbouring engines; a stray
    // pulse while no operation runs must not raise the flag
    if (eng_done || (ext_done && trig_q && func_q != FUNC_LINE)) begin
      trig_d = 1'b0;
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      func_q  <= 3'h0;
      trig_q  <= 1'b0;
      flag_q  <= 1'b0;
      ien_q   <= 1'b0;
      obase_q <= RST_BASE;
      ostr_q  <= RST_DIM;
      x1_q    <= RST_DIM;
      y1_q    <= RST_DIM;
      x2_q    <= RST_DIM;
      y2_q    <= RST_DIM;
      thick_q <= RST_DIM;
      color_q <= 8'h00;
      owid_q  <= RST_DIM;
      ohgt_q  <= RST_DIM;
      pcfg_q  <= 6'h00;
      swid_q  <= RST_DIM;
      shgt_q  <= RST_DIM;
      sstr_q  <= RST_DIM;
      sbase_q <= RST_BASE;
      rdata_q <= 32'h0000_0000;
    end else begin
      func_q  <= func_d;
      trig_q  <= trig_d;
      flag_q  <= flag_d;
      ien_q   <= ien_d;
      obase_q <= obase_d;
      ostr_q  <= ostr_d;
      x1_q    <= x1_d;
      y1_q    <= y1_d;
      x2_q    <= x2_d;
      y2_q    <= y2_d;
      thick_q <= thick_d;
      color_q <= color_d;
      owid_q  <= owid_d;
      ohgt_q  <= ohgt_d;
      pcfg_q  <= pcfg_d;
      swid_q  <= swid_d;
      shgt_q  <= shgt_d;
      sstr_q  <= sstr_d;
      sbase_q <= sbase_d;
      rdata_q <= rdata_d;
    end
  end

  // scan geometry goes to the panel updater as software set it up;
  // the odd rectangular cases are worked around by software offsets
  always_comb begin
    scan_cfg.base   = sbase_q;
    scan_cfg.width  = swid_q;
    scan_cfg.height = shgt_q;
    scan_cfg.stride = sstr_q;
    scan_cfg.fmt    = pcfg_q[1:0];
    // grayscale panels cannot rotate, so they see 0 degrees
    scan_cfg.rot    = (pcfg_q[5:4] == PT_COLOR || pcfg_q[5:4] == PT_SERIAL)
                      ? pcfg_q[3:2] : 2'h0;
  end

  assign reg_rdata         = rdata_q;
  assign irq               = flag_q & ien_q;
  assign function_select   = func_q;
  assign operation_trigger = trig_q;
  assign mem_wr            = mem_q;

  // ==========================================================
  // pixel of the current span: x-major lines grow vertically
  always_comb begin
    nthick = -$signed({2'b00, thick_q});
    px     = xmaj_q ? cx_q : 12'(cx_q + off_q);
    py     = xmaj_q ? 12'(cy_q + off_q) : cy_q;
    // origin top left, pixels off the buffer are dropped
    inb    = !px[11] && !py[11] && (px[9:0] < owid_q) && (py[9:0] < ohgt_q)
             && (px[10] == 1'b0) && (py[10] == 1'b0);
    yoff   = py[9:0] * line_bytes(ostr_q, pcfg_q[1:0]);
    case (pcfg_q[1:0])
      FMT_C3: begin
        xbyte = {1'b0, px[9:1]};
        pmask = px[0] ? 8'hf0 : 8'h0f;
        pdata = px[0] ? {color_q[3:0], 4'h0} : {4'h0, color_q[3:0]};
      end
      FMT_MONO: begin
        xbyte = {2'b00, px[9:2]};
        pmask = 8'(8'h03 << {px[1:0], 1'b0});
        pdata = 8'({6'h00, color_q[1:0]} << {px[1:0], 1'b0});
      end
      default: begin
        xbyte = px[9:0];
        pmask = 8'hff;
        pdata = color_q;
      end
    endcase
    adv    = !mem_q.req || mem_ready;
    at_end = (cx_q == $signed({2'b00, x2_q})) && (cy_q == $signed({2'b00, y2_q}));
    e2     = err_q <<< 1;
  end

  // ==========================================================
  // engine: one span of 2t+1 pixels per step of the line walk
  always_comb begin
    st_d   = st_q;
    cx_d   = cx_q;
    cy_d   = cy_q;
    off_d  = off_q;
    err_d  = err_q;
    dx_d   = dx_q;
    dy_d   = dy_q;
    sxn_d  = sxn_q;
    syn_d  = syn_q;
    xmaj_d = xmaj_q;
    mem_d  = mem_q;
    if (mem_ready) mem_d.req = 1'b0;
    eng_done = 1'b0;
    case (st_q)
      ST_IDLE: begin
        if (trig_q && func_q == FUNC_LINE) begin
          cx_d   = $signed({2'b00, x1_q});
          cy_d   = $signed({2'b00, y1_q});
          dx_d   = abs_diff(x2_q, x1_q);
          dy_d   = abs_diff(y2_q, y1_q);
          sxn_d  = x2_q < x1_q;
          syn_d  = y2_q < y1_q;
          xmaj_d = abs_diff(x2_q, x1_q) >= abs_diff(y2_q, y1_q);
          err_d  = 13'($signed({1'b0, abs_diff(x2_q, x1_q)})
                   - $signed({1'b0, abs_diff(y2_q, y1_q)}));
          off_d  = nthick;
          st_d   = ST_SPAN;
        end
      end
      ST_SPAN: begin
        if (adv) begin
          if (inb) begin
            mem_d.req  = 1'b1;
            mem_d.addr = obase_q + {12'h000, yoff} + {22'h0, xbyte};
            mem_d.data = pdata;
            mem_d.mask = pmask;
          end
          off_d = 12'(off_q + 12'sd1);
          if (off_q == $signed({2'b00, thick_q})) begin
            off_d = nthick;
            st_d  = at_end ? ST_DONE : ST_STEP;
          end
        end
      end
      ST_STEP: begin
        if (e2 > -$signed({1'b0, dy_q})) begin
          err_d = 13'(err_d - $signed({1'b0, dy_q}));
          cx_d  = sxn_q ? 12'(cx_q - 12'sd1) : 12'(cx_q + 12'sd1);
        end
        if (e2 < $signed({1'b0, dx_q})) begin
          err_d = 13'(err_d + $signed({1'b0, dx_q}));
          cy_d  = syn_q ? 12'(cy_q - 12'sd1) : 12'(cy_q + 12'sd1);
        end
        st_d = ST_SPAN;
      end
      ST_DONE: begin
        // wait for the last pixel write to drain before finishing
        if (adv) begin
          eng_done = 1'b1;
          st_d     = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_q   <= ST_IDLE;
      cx_q   <= 12'sd0;
      cy_q   <= 12'sd0;
      off_q  <= 12'sd0;
      err_q  <= 13'sd0;
      dx_q   <= 12'h000;
      dy_q   <= 12'h000;
      sxn_q  <= 1'b0;
      syn_q  <= 1'b0;
      xmaj_q <= 1'b0;
      mem_q  <= '0;
    end else begin
      st_q   <= st_d;
      cx_q   <= cx_d;
      cy_q   <= cy_d;
      off_q  <= off_d;
      err_q  <= err_d;
      dx_q   <= dx_d;
      dy_q   <= dy_d;
      sxn_q  <= sxn_d;
      syn_q  <= syn_d;
      xmaj_q <= xmaj_d;
      mem_q  <= mem_d;
    end
  end

endmodule : frld_line_engine

// File: verilog/frld_pkg.sv
// constants, types and register map of the line draw engine
// Function
// - rotation 0/90/180/270 applies only to colour and serial panel types.
// - line bytes: stride for 6-bit, stride/2 up for 3-bit, stride/4 up for mono.
// - origin top left, X grows right, Y grows down, coordinates positive.
// - drawing touches only frame buffer memory, never refreshes the panel.
// - line drawn when function select is 3 and trigger written 1.
// - start from first point, end at second, base from halves, pitch from stride.
// - on completion trigger self-clears and completion flag sets.
// - line thickness is twice the thickness parameter plus one pixel.
// - pixels take the eight-bit pen value as colour or gray level; the code uses only pen bits 3:0 for 3-bit and 1:0 for mono.
// - writing 1 clears completion flag; enable bit gates it onto interrupt.
package frld_pkg;

  // ==========================================================
  // register byte addresses
  localparam logic [7:0] REG_FUNC   = 8'h00;
  localparam logic [7:0] REG_TRIG   = 8'h04;
  localparam logic [7:0] REG_INTST  = 8'h08;
  localparam logic [7:0] REG_INTEN  = 8'h0c;
  localparam logic [7:0] REG_OBLO   = 8'h10;
  localparam logic [7:0] REG_OBHI   = 8'h14;
  localparam logic [7:0] REG_OSTR   = 8'h18;
  localparam logic [7:0] REG_X1     = 8'h1c;
  localparam logic [7:0] REG_Y1     = 8'h20;
  localparam logic [7:0] REG_X2     = 8'h24;
  localparam logic [7:0] REG_Y2     = 8'h28;
  localparam logic [7:0] REG_THICK  = 8'h2c;
  localparam logic [7:0] REG_COLOR  = 8'h30;
  localparam logic [7:0] REG_OWID   = 8'h34;
  localparam logic [7:0] REG_OHGT   = 8'h38;
  localparam logic [7:0] REG_PCFG   = 8'h3c;
  localparam logic [7:0] REG_SWID   = 8'h40;
  localparam logic [7:0] REG_SHGT   = 8'h44;
  localparam logic [7:0] REG_SSTR   = 8'h48;
  localparam logic [7:0] REG_SBLO   = 8'h4c;
  localparam logic [7:0] REG_SBHI   = 8'h50;
  localparam logic [7:0] REG_STAT   = 8'h54;

  // ==========================================================
  // field codes and reset values
  localparam logic [2:0] FUNC_LINE  = 3'h3;
  localparam logic [1:0] FMT_C6     = 2'h0;
  localparam logic [1:0] FMT_C3     = 2'h1;
  localparam logic [1:0] FMT_MONO   = 2'h2;
  localparam logic [1:0] PT_COLOR   = 2'h0;
  localparam logic [1:0] PT_SERIAL  = 2'h1;
  localparam logic [9:0] RST_DIM    = 10'h000;
  localparam logic [31:0] RST_BASE  = 32'h0000_0000;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SPAN = 2'b01,
    ST_STEP = 2'b10,
    ST_DONE = 2'b11
  } frld_state_e;

  typedef struct packed {
    logic [31:0] base;
    logic [9:0]  width;
    logic [9:0]  height;
    logic [9:0]  stride;
    logic [1:0]  rot;
    logic [1:0]  fmt;
  } frld_scan_s;

  typedef struct packed {
    logic        req;
    logic [31:0] addr;
    logic [7:0]  data;
    logic [7:0]  mask;
  } frld_mem_s;

endpackage : frld_pkg

// File: tb/frld_props.sv
// concurrent checks on the ports of the line draw engine
module frld_props
  import frld_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        irq,
  input wire logic [2:0]  function_select,
  input wire logic        operation_trigger,
  input wire logic        ext_done,
  input wire frld_scan_s  scan_cfg,
  input wire frld_mem_s   mem_wr,
  input wire logic        mem_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // one clock domain, so clock and reset are given once
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  a_trig_from_write: assert property (
    $rose(operation_trigger) |-> $past(reg_wr && reg_addr == REG_TRIG && reg_wdata[0]))
    else $error("trigger rose without a trigger write");
  a_func_field: assert property (
    reg_wr && reg_addr == REG_FUNC |=> function_select == $past(reg_wdata[2:0]))
    else $error("function field not taken from write");
  a_irq_rise_cause: assert property (
    $rose(irq) |-> $fell(operation_trigger) || $past(reg_wr && reg_addr == REG_INTEN))
    else $error("irq rose without completion or enable");
  a_irq_fall_cause: assert property (
    $fell(irq) |-> $past(reg_wr && (reg_addr == REG_INTST || reg_addr == REG_INTEN)
                         || reg_rd && reg_addr == REG_INTST))
    else $error("irq fell without clear or mask");
  a_write_held: assert property (
    mem_wr.req && !mem_ready |=> mem_wr.req && $stable(mem_wr))
    else $error("pixel write changed before acceptance");
  a_write_in_line: assert property (
    mem_wr.req |-> operation_trigger && function_select == FUNC_LINE)
    else $error("memory write outside a line operation");
  a_rot_gated: assert property (
    reg_wr && reg_addr == REG_PCFG |=>
      scan_cfg.rot == ($past(reg_wdata[5]) ? 2'h0 : $past(reg_wdata[3:2])))
    else $error("rotation not gated by panel type");
  a_fmt_pass: assert property (
    reg_wr && reg_addr == REG_PCFG |=> scan_cfg.fmt == $past(reg_wdata[1:0]))
    else $error("format field not passed on");
  a_mono_mask: assert property (
    mem_wr.req && scan_cfg.fmt == FMT_MONO |-> $countones(mem_wr.mask) == 2)
    else $error("mono pixel mask not two bits");
  a_ext_finish: assert property (
    operation_trigger && function_select != FUNC_LINE && ext_done |-> ##[1:3] !operation_trigger)
    else $error("trigger did not clear after outside completion");
endmodule : frld_props

bind frld_line_engine frld_props chk_u (
  .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
  .function_select(function_select), .operation_trigger(operation_trigger),
  .ext_done(ext_done), .scan_cfg(scan_cfg), .mem_wr(mem_wr), .mem_ready(mem_ready)
);

// File: tb/frld_mem_model.sv
// frame buffer memory that takes the engine's pixel writes
module frld_mem_model
  import frld_pkg::*;
(
  input  wire logic  sys_clk,
  input  wire logic  resetn,
  input  wire frld_mem_s mem_wr,
  input  wire logic  slow,
  output logic       mem_ready,
  output logic [15:0] wr_count
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0]  mem [0:255];
  logic [31:0] last_addr;
  logic        ph_q;

  initial for (int i = 0; i < 256; i++) mem[i] = 8'h00;
  // slow mode accepts every other cycle so held requests are exercised
  assign mem_ready = !slow || ph_q;
  // byte merge under mask; each accepted write also records last_addr and counts up wr_count
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ph_q <= 1'b0;
      wr_count <= 16'h0;
    end else begin
      ph_q <= !ph_q;
      if (mem_wr.req && mem_ready) begin
        mem[mem_wr.addr[7:0]] <= (mem[mem_wr.addr[7:0]] & ~mem_wr.mask)
                                 | (mem_wr.data & mem_wr.mask);
        last_addr <= mem_wr.addr;
        wr_count <= wr_count + 16'h1;
      end
    end
  end
endmodule : frld_mem_model

// File: tb/frld_line_engine_tb.sv
// self-checking bench of the line draw engine
module frld_line_engine_tb
  import frld_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic ext_done = 1'b0, slow = 1'b0, irq, operation_trigger, mem_ready;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rd_q;
  logic [2:0]  function_select;
  logic [15:0] wr_count;
  frld_scan_s  scan_cfg;
  frld_mem_s   mem_wr;
  int fail_count = 0, check_count = 0, cyc = 0;

  frld_line_engine dut_u (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq(irq), .function_select(function_select), .operation_trigger(operation_trigger),
    .ext_done(ext_done), .scan_cfg(scan_cfg), .mem_wr(mem_wr), .mem_ready(mem_ready));
  frld_mem_model mem_u (.sys_clk(sys_clk), .resetn(resetn), .mem_wr(mem_wr),
    .slow(slow), .mem_ready(mem_ready), .wr_count(wr_count));

  // ==========================================================
  // clock and hang guard
  initial forever #12.5 sys_clk = !sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      summarize;
    end
  end

  // ==========================================================
  // shared tasks
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // a gap cycle after each strobe keeps one assignment per time step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rd_q = reg_rdata;
  endtask : rd
  task automatic settle;
    @(posedge sys_clk);
    #1;
  endtask : settle
  task automatic run(input logic [2:0] f);
    int n;
    wr(REG_FUNC, {29'h0, f});
    wr(REG_TRIG, 32'h1);
    n = 0;
    #1;
    while (operation_trigger !== 1'b0 && n < 400) begin
      settle;
      n++;
    end
    chk({31'h0, operation_trigger}, 32'h0);
  endtask : run
  // scan geometry packed into one word: width, height, stride, rotation
  function automatic logic [31:0] geo();
    geo = {scan_cfg.width, scan_cfg.height, scan_cfg.stride, scan_cfg.rot};
  endfunction : geo
  // software side of a panel setup: scan and drawing settings, serial panel
  task automatic scan_set(input logic [1:0] r, input logic [9:0] w, h, s, ow, oh, os,
                          input logic [31:0] b);
    wr(REG_PCFG, {26'h0, PT_SERIAL, r, FMT_C6});
    wr(REG_SWID, {22'h0, w});
    wr(REG_SHGT, {22'h0, h});
    wr(REG_SSTR, {22'h0, s});
    wr(REG_SBLO, {16'h0, b[15:0]});
    wr(REG_SBHI, {16'h0, b[31:16]});
    wr(REG_OWID, {22'h0, ow});
    wr(REG_OHGT, {22'h0, oh});
    wr(REG_OSTR, {22'h0, os});
    settle;
  endtask : scan_set
  task automatic line(input logic [1:0] f, input logic [9:0] s, x1, y1, x2, y2, t,
                      input logic [7:0] pen);
    wr(REG_PCFG, {30'h0, f});
    wr(REG_OSTR, {22'h0, s});
    wr(REG_X1, {22'h0, x1});
    wr(REG_Y1, {22'h0, y1});
    wr(REG_X2, {22'h0, x2});
    wr(REG_Y2, {22'h0, y2});
    wr(REG_THICK, {22'h0, t});
    wr(REG_COLOR, {24'h0, pen});
    run(FUNC_LINE);
  endtask : line

  // ==========================================================
  // scenarios
  task automatic t_regs;
    rd(REG_FUNC);
    chk(rd_q, 32'h0);
    rd(8'hfc);
    chk(rd_q, 32'h0);
    wr(REG_OBLO, 32'h40);
    wr(REG_OBHI, 32'h1);
    rd(REG_OBHI);
    chk(rd_q, 32'h1);
    wr(REG_OWID, 32'h10);
    wr(REG_OHGT, 32'h10);
  endtask : t_regs
  // single dots in each pixel packing, with irq and flag handling on the first
  task automatic t_dots;
    logic [15:0] c0;
    c0 = wr_count;
    wr(REG_INTEN, 32'h1);
    line(FMT_C6, 10'd16, 10'd2, 10'd1, 10'd2, 10'd1, 10'd0, 8'h5a);
    chk({24'h0, mem_u.mem[8'h52]}, 32'h5a);
    chk(mem_u.last_addr, 32'h0001_0052);
    chk({31'h0, irq}, 32'h1);
    wr(REG_INTEN, 32'h0);
    settle;
    chk({31'h0, irq}, 32'h0);
    wr(REG_INTEN, 32'h1);
    settle;
    chk({31'h0, irq}, 32'h1);
    wr(REG_INTST, 32'h1);
    settle;
    chk({31'h0, irq}, 32'h0);
    line(FMT_C3, 10'd5, 10'd3, 10'd1, 10'd3, 10'd1, 10'd0, 8'h07);
    chk({24'h0, mem_u.mem[8'h44]}, 32'h70);
    rd(REG_INTST);
    chk(rd_q, 32'h1);
    rd(REG_INTST);
    chk(rd_q, 32'h0);
    line(FMT_MONO, 10'd7, 10'd5, 10'd2, 10'd5, 10'd2, 10'd0, 8'h03);
    chk({24'h0, mem_u.mem[8'h45]}, 32'h0c);
    chk({16'h0, wr_count - c0}, 32'h3);
    wr(REG_INTEN, 32'h0);
  endtask : t_dots
  // thick flat line under a stalling memory: 3 columns by 2t+1 rows
  task automatic t_thick;
    logic [15:0] c0;
    c0 = wr_count;
    slow <= 1'b1;
    line(FMT_C6, 10'd16, 10'd3, 10'd4, 10'd5, 10'd4, 10'd1, 8'h33);
    slow <= 1'b0;
    chk({16'h0, wr_count - c0}, 32'h9);
    chk({24'h0, mem_u.mem[8'h73]}, 32'h33);
    chk({24'h0, mem_u.mem[8'h95]}, 32'h33);
    chk({24'h0, mem_u.mem[8'ha4]}, 32'h0);
    chk({24'h0, mem_u.mem[8'h86]}, 32'h0);
  endtask : t_thick
  // rotation only for colour and serial panel types; scan settings pass through
  task automatic t_rot;
    logic [1:0] ty [3] = '{2'h0, 2'h1, 2'h2};
    logic [1:0] ro [3] = '{2'h1, 2'h3, 2'h2};
    logic [1:0] ex [3] = '{2'h1, 2'h3, 2'h0};
    for (int i = 0; i < 3; i++) begin
      wr(REG_PCFG, {26'h0, ty[i], ro[i], FMT_C3});
      settle;
      chk({30'h0, scan_cfg.rot}, {30'h0, ex[i]});
    end
    wr(REG_SWID, 32'd20);
    wr(REG_SBLO, 32'h1234);
    wr(REG_SBHI, 32'h5);
    settle;
    chk({22'h0, scan_cfg.width}, 32'd20);
    chk(scan_cfg.base, 32'h0005_1234);
  endtask : t_rot
  // another function waits for the outside engine before completing
  task automatic t_ext;
    fork
      run(3'h6);
      begin
        repeat (10) @(posedge sys_clk);
        #1 chk({31'h0, operation_trigger}, 32'h1);
        @(posedge sys_clk);
        ext_done <= 1'b1;
        @(posedge sys_clk);
        ext_done <= 1'b0;
      end
    join
    rd(REG_INTST);
    chk(rd_q, 32'h1);
    chk({29'h0, function_select}, 32'h6);
  endtask : t_ext
  // each panel shape and the rotations 1 to 3: settings reach the panel updater unchanged
  task automatic t_scan;
    scan_set(2'h1, 10'd16, 10'd16, 10'd16, 10'd16, 10'd16, 10'd16, 32'h0001_0040);
    chk(geo(), {10'd16, 10'd16, 10'd16, 2'h1});
    scan_set(2'h2, 10'd20, 10'd12, 10'd20, 10'd20, 10'd12, 10'd20, 32'h0001_0040);
    chk(geo(), {10'd20, 10'd12, 10'd20, 2'h2});
    chk(scan_cfg.base, 32'h0001_0040);
    scan_set(2'h1, 10'd20, 10'd20, 10'd20, 10'd12, 10'd12, 10'd20, 32'h0001_0038);
    chk(geo(), {10'd20, 10'd20, 10'd20, 2'h1});
    chk(scan_cfg.base, 32'h0001_0038);
    rd(REG_OSTR);
    chk(rd_q, 32'd20);
    scan_set(2'h1, 10'd20, 10'd20, 10'd20, 10'd20, 10'd12, 10'd20, 32'h0001_0040);
    chk(geo(), {10'd20, 10'd20, 10'd20, 2'h1});
    scan_set(2'h3, 10'd20, 10'd20, 10'd20, 10'd12, 10'd20, 10'd20, 32'h0001_0040);
    chk(geo(), {10'd20, 10'd20, 10'd20, 2'h3});
    scan_set(2'h3, 10'd20, 10'd20, 10'd20, 10'd20, 10'd12, 10'd20, 32'h0000_ffa0);
    chk(scan_cfg.base, 32'h0000_ffa0);
    rd(REG_OHGT);
    chk(rd_q, 32'd12);
  endtask : t_scan

  initial begin
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    t_regs;
    t_dots;
    t_thick;
    t_rot;
    t_ext;
    t_scan;
    summarize;
  end
endmodule : frld_line_engine_tb
